/* File: logic/cbc_bus_ctrl.sv */
// Local bus control, byte lanes, read strobe and system inputs.
// Assumes ready arrives already synchronized and requests come from
// the execution core through a 16-entry request FIFO.
`timescale 1ns/1ps

module cbc_bus_ctrl
  import cbc_pkg::*;
(
  input  wire logic             clk,                 // 100 MHz clock
  input  wire logic             nrst,                // Sync reset, low
  input  wire logic             req_valid,           // Bus cycle request
  input  wire cbc_req_t         req,                 // Request details
  output logic                  req_ready,           // FIFO has room
  input  wire logic             instr_last,          // Last instr cycle
  input  wire logic             irq_enable_flag,     // Software enable
  input  wire logic [7:0]       inta_type,           // Type from ack
  input  wire logic             wait_exec,           // Wait instr active
  input  wire logic             ready,               // Transfer ready
  input  wire logic             hold_req,            // Bus hold request
  input  wire logic             maskable_irq,        // Level request
  input  wire logic             nonmaskable_irq,     // Edge request
  input  wire logic             wait_release_input,  // Wait release pin
  input  wire logic             sys_reset,           // Reset pin, high
  input  wire logic             config_mode_strap,   // Mode strap
  output logic                  upper_half_enable_n, // Upper enable/S7
  output logic                  upper_half_enable_oe,// Driver enable
  output logic                  low_byte_select_n,   // Lower lane
  output logic                  low_byte_select_oe,  // Driver enable
  output logic                  read_strobe_n,       // Read strobe
  output logic                  read_strobe_oe,      // Driver enable
  output logic                  ad_drive_oe,         // Address drivers
  output logic                  hold_ack,            // Hold granted
  output logic                  cycle_done,          // T4 pulse
  output logic                  irq_take,            // Interrupt pulse
  output logic                  irq_nmi,             // Taken is NMI
  output logic      [VEC_W-1:0] vector_addr,         // Table address
  output logic                  wait_idle,           // Wait stays idle
  output logic                  exec_restart,        // Restart pulse
  output logic                  mode_max             // Maximum mode
);

  // -----------------------------------------------------------------
  // Input synchronizers
  // -----------------------------------------------------------------
  logic [3:0] sync_q;
  logic       irq_sync;
  logic       nmi_sync;
  logic       release_sync;
  logic       reset_sync;

  cbc_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({sys_reset, wait_release_input, nonmaskable_irq,
            maskable_irq}),                                   // [R10] [R14]
    .q    (sync_q)
  );

  assign irq_sync     = sync_q[0];
  assign nmi_sync     = sync_q[1];
  assign release_sync = sync_q[2];
  assign reset_sync   = sync_q[3];

  // -----------------------------------------------------------------
  // Request FIFO
  // -----------------------------------------------------------------
  logic       fifo_out_valid;
  logic       fifo_pop;
  cbc_req_t   fifo_out;
  cbc_req_t   cur_req_reg;
  cbc_req_t   req_sel;
  logic       req_ready_reg;
  logic       fifo_in_ready;

  cbc_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (reset_sync),
    .in_valid  (req_valid && req_ready_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (req),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // Registered ready; dropping it for one cycle after each accept keeps it honest
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_ready_reg <= 1'b0;
    end else begin
      req_ready_reg <= fifo_in_ready && !reset_sync &&
                       !(req_valid && req_ready_reg);
    end
  end

  assign req_ready = req_ready_reg;

  // -----------------------------------------------------------------
  // Bus state machine
  // -----------------------------------------------------------------
  cbc_state_t st_reg;
  cbc_state_t st_next;

  assign fifo_pop = (st_reg == ST_IDLE) && !hold_req && fifo_out_valid &&
                    !reset_sync;
  assign req_sel  = fifo_pop ? fifo_out : cur_req_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (hold_req) begin
          st_next = ST_HOLD;
        end else if (fifo_pop) begin
          st_next = ST_T1;
        end
      end
      ST_T1: begin
        st_next = ST_T2;
      end
      ST_T2: begin
        st_next = ST_T3;
      end
      ST_T3: begin
        st_next = ready ? ST_T4 : ST_TW;                         // [R22]
      end
      ST_TW: begin
        st_next = ready ? ST_T4 : ST_TW;                         // [R22]
      end
      ST_T4: begin
        st_next = ST_IDLE;
      end
      ST_HOLD: begin
        if (!hold_req) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    if (reset_sync) begin
      st_next = ST_IDLE;                                         // [R18]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cur_req_reg <= '0;
    end else if (fifo_pop) begin
      cur_req_reg <= fifo_out;
    end
  end

  // -----------------------------------------------------------------
  // Pin drive, computed from the next state
  // -----------------------------------------------------------------
  logic [1:0] lane_next;
  logic       in_data_phase;
  logic       is_read;

  always_comb begin
    if (req_sel.word) begin
      lane_next = LANE_WORD;                                     // [R02]
    end else if (req_sel.odd_addr) begin
      lane_next = LANE_ODD;                                      // [R02]
    end else begin
      lane_next = LANE_EVEN;                                     // [R02]
    end
  end

  assign in_data_phase = (st_next == ST_T2) || (st_next == ST_T3) ||
                         (st_next == ST_TW) || (st_next == ST_T4);
  assign is_read       = (req_sel.kind == KIND_READ);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      upper_half_enable_n <= 1'b1;
      low_byte_select_n   <= 1'b1;
    end else if (st_next == ST_T1) begin
      if (req_sel.kind == KIND_INTA && req_sel.first_inta) begin
        upper_half_enable_n <= 1'b0;                             // [R04]
      end else begin
        upper_half_enable_n <= lane_next[1];                     // [R01]
      end
      low_byte_select_n <= lane_next[0];                         // [R21]
    end else if (in_data_phase) begin
      upper_half_enable_n <= STATUS_S7;                          // [R03]
      low_byte_select_n   <= LANE_NONE[0];
    end else begin
      upper_half_enable_n <= LANE_NONE[1];
      low_byte_select_n   <= LANE_NONE[0];
    end
  end

  // Strobe goes low on the same edge that floats the address drivers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_strobe_n <= 1'b1;
      ad_drive_oe   <= 1'b0;
    end else begin
      read_strobe_n <= !(is_read && ((st_next == ST_T2) ||
                         (st_next == ST_T3) || (st_next == ST_TW)));  // [R05]
      ad_drive_oe   <= (st_next == ST_T1);                       // [R05]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      upper_half_enable_oe <= 1'b0;
      read_strobe_oe       <= 1'b0;
      low_byte_select_oe   <= 1'b0;
      hold_ack             <= 1'b0;
      cycle_done           <= 1'b0;
    end else begin
      upper_half_enable_oe <= (st_next != ST_HOLD);              // [R06]
      read_strobe_oe       <= (st_next != ST_HOLD);              // [R06]
      low_byte_select_oe   <= (st_next == ST_T1);                // [R21]
      hold_ack             <= (st_next == ST_HOLD);              // [R06]
      cycle_done           <= (st_next == ST_T4);
    end
  end

  // -----------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------
  logic nmi_prev_reg;
  logic nmi_pend_reg;
  logic nmi_edge;
  logic irq_fire;

  assign nmi_edge = nmi_sync && !nmi_prev_reg;                   // [R16]
  assign irq_fire = instr_last && !reset_sync &&
                    (nmi_pend_reg || (irq_sync && irq_enable_flag));  // [R09] [R11]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      nmi_prev_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_sync;
    end
  end

  // New edge wins over the clear from a take
  always_ff @(posedge clk) begin
    if (!nrst || reset_sync) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_reg <= 1'b1;                                      // [R16]
    end else if (irq_fire) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_take    <= 1'b0;
      irq_nmi     <= 1'b0;
      vector_addr <= '0;
    end else begin
      irq_take <= irq_fire;
      if (irq_fire) begin
        irq_nmi <= nmi_pend_reg;
        if (nmi_pend_reg) begin
          vector_addr <= {NMI_TYPE, 2'h0};                       // [R12] [R15]
        end else begin
          vector_addr <= {inta_type, 2'h0};                      // [R12]
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Wait instruction, reset release and mode strap
  // -----------------------------------------------------------------
  logic reset_prev_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_idle <= 1'b0;
    end else begin
      wait_idle <= wait_exec && release_sync;                    // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reset_prev_reg <= 1'b0;
      exec_restart   <= 1'b0;
    end else begin
      reset_prev_reg <= reset_sync;
      exec_restart   <= reset_prev_reg && !reset_sync;           // [R18]
    end
  end

  // Strap low selects maximum mode; caught while reset is held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_max <= 1'b0;
    end else if (reset_sync) begin
      mode_max <= !config_mode_strap;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic is_read_cur;
  assign is_read_cur = (cur_req_reg.kind == KIND_READ);

  sequence read_addr_s;
    (st_reg == ST_T1) && (cur_req_reg.kind == KIND_READ) && read_strobe_n;
  endsequence

  sequence read_data_s;
    !read_strobe_n && !ad_drive_oe;
  endsequence

  upper_lane_a: assert property (                                // [R01]
    (st_reg == ST_T1) && (cur_req_reg.word || cur_req_reg.odd_addr)
    |-> !upper_half_enable_n)
    else $error("upper enable not low for upper byte");

  lane_code_a: assert property (                                 // [R02]
    (st_reg == ST_T1) && !cur_req_reg.word && !cur_req_reg.odd_addr &&
    !(cur_req_reg.kind == KIND_INTA && cur_req_reg.first_inta)
    |-> upper_half_enable_n && !low_byte_select_n)
    else $error("even byte lane code wrong");

  status_phase_a: assert property (                              // [R03]
    $past(st_reg == ST_T1) && !reset_prev_reg
    |-> upper_half_enable_n == STATUS_S7 [*2])
    else $error("status bit missing after T1");

  inta_first_a: assert property (                                // [R04]
    (st_reg == ST_T1) && (cur_req_reg.kind == KIND_INTA) &&
    cur_req_reg.first_inta |-> !upper_half_enable_n)
    else $error("upper enable high in first acknowledge");

  read_strobe_a: assert property (                               // [R05]
    read_addr_s ##1 (st_reg == ST_T2) |-> read_data_s)
    else $error("read strobe not low after address float");

  hold_float_a: assert property (                                // [R06]
    hold_ack |-> !upper_half_enable_oe && !read_strobe_oe)
    else $error("pins driven during hold");

  irq_mask_a: assert property (                                  // [R11]
    irq_take && !irq_nmi |-> $past(irq_enable_flag) && $past(instr_last))
    else $error("masked request taken");

  nmi_vector_a: assert property (                                // [R15]
    irq_take && irq_nmi |-> vector_addr == {NMI_TYPE, 2'h0})
    else $error("non-maskable vector wrong");

  nmi_unmask_a: assert property (                                // [R16]
    nmi_pend_reg && instr_last && !irq_enable_flag && !reset_sync
    |=> irq_take && irq_nmi)
    else $error("non-maskable request not taken");

  wait_idle_a: assert property (                                 // [R13]
    wait_exec && release_sync |=> wait_idle)
    else $error("wait did not idle");

  abandon_now_a: assert property (                               // [R18]
    reset_sync |=> (st_reg == ST_IDLE) && read_strobe_n)
    else $error("activity not abandoned on reset");

  wait_insert_a: assert property (                               // [R22]
    (st_reg == ST_T3) && !ready && !reset_sync
    |=> (st_reg == ST_TW) && (!read_strobe_n || !is_read_cur))
    else $error("wait state not inserted");

endmodule

/* File: pkg/cbc_pkg.sv */
// Shared types and constants for the local bus control block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
//
// Overview of operation
// [R01] Upper enable low in T1 when the upper data byte moves.
// [R02] Upper enable and low select encode word, odd, even or none.
// [R03] Status bit seven replaces upper enable during T2, T3 and T4.
// [R04] Upper enable low in T1 of the first interrupt acknowledge.
// [R05] Read strobe low in T2, T3, wait states; high until bus floats.
// [R06] Read strobe and upper enable float while hold is acknowledged.
// [R07] Addressed device raises ready when it will finish the transfer.
// [R08] Clock generator synchronizes ready; this block samples it raw.
// [R09] Maskable request sampled in the last cycle of each instruction.
// [R10] Maskable request is active-high, level-sensitive, synchronized.
// [R11] Maskable request ignored while the interrupt enable flag is clear.
// [R12] Both interrupts locate their routine through a vector table.
// [R13] Wait instruction continues on low release input, else idles.
// [R14] Wait release input is synchronized on every clock edge.
// [R15] Non-maskable request is edge-sensitive and raises type 2.
// [R16] Rising edge starts the interrupt at instruction end; unmaskable.
// [R17] System holds reset high for at least four clocks.
// [R18] Reset synchronized, abandons activity at once, restarts on release.
// [R19] Clock source supplies a 33 percent high-phase clock.
// [R20] System drives the mode strap for minimum or maximum mode.
// [R21] Low select low in T1 when the lower data byte moves.
// [R22] Ready low after T3 inserts wait states, strobe held until ready.

package cbc_pkg;

  // -----------------------------------------------------------------
  // Bus cycle requests
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_READ  = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_INTA  = 2'h2
  } cbc_kind_t;

  typedef struct packed {
    cbc_kind_t kind;
    logic      first_inta;
    logic      odd_addr;
    logic      word;
  } cbc_req_t;

  localparam int REQ_W      = $bits(cbc_req_t);
  localparam int FIFO_DEPTH = 16;

  // -----------------------------------------------------------------
  // Lane codes {upper_half_enable_n, low_byte_select_n}
  // -----------------------------------------------------------------
  localparam logic [1:0] LANE_WORD = 2'h0;
  localparam logic [1:0] LANE_ODD  = 2'h1;
  localparam logic [1:0] LANE_EVEN = 2'h2;
  localparam logic [1:0] LANE_NONE = 2'h3;

  localparam logic       STATUS_S7 = 1'h0;
  localparam logic [7:0] NMI_TYPE  = 8'h02;
  localparam int         VEC_W     = 10;

  // -----------------------------------------------------------------
  // Bus T-states
  // -----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_T1   = 7'h02,
    ST_T2   = 7'h04,
    ST_T3   = 7'h08,
    ST_TW   = 7'h10,
    ST_T4   = 7'h20,
    ST_HOLD = 7'h40
  } cbc_state_t;

endpackage

/* File: logic/cbc_sync.sv */
// Two-stage synchronizer for a vector of pin inputs.
// Assumes the first stage is read only by the second.
`timescale 1ns/1ps

module cbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         nrst,  // Synchronous reset, active low
  input  wire logic [W-1:0] d,     // Asynchronous inputs
  output logic      [W-1:0] q      // Synchronized outputs
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

/* File: logic/cbc_fifo.sv */
// Request FIFO with valid/ready on both sides and a flush input.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps

module cbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,        // System clock
  input  wire logic             nrst,       // Synchronous reset, active low
  input  wire logic             flush,      // Drop all entries
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Space available
  input  wire logic [WIDTH-1:0] in_data,    // Write data
  output logic                  out_valid,  // Entry available
  input  wire logic             out_ready,  // Read accept
  output logic      [WIDTH-1:0] out_data    // Head entry
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

/* File: dv/cbc_mem_model.sv */
// Memory or I/O partner that answers each bus cycle with ready.
// Assumes T1 is marked by the bus controller's address enable.
`timescale 1ns/1ps

module cbc_mem_model (
  input  wire logic       clk,      // System clock
  input  wire logic       nrst,     // Sync reset, active low
  input  wire logic       t1_mark,  // Address phase
  input  wire logic [3:0] waits,    // Wait states to insert
  output logic            ready     // Transfer ready
);
  // ---------------------------------------------------------------
  // Ready timing
  // ---------------------------------------------------------------
  logic [4:0] cnt_reg;

  // Registered, so ready reaches the block already synchronized
  always_ff @(posedge clk) begin
    if (!nrst)
      cnt_reg <= 5'h00;
    else if (t1_mark)
      cnt_reg <= {1'b0, waits} + 5'h01;
    else if (cnt_reg != 5'h00)
      cnt_reg <= cnt_reg - 5'h01;
  end

  assign ready = (cnt_reg == 5'h00);
endmodule

/* File: dv/tb_cbc_bus_ctrl.sv */
// Self-checking bench for the local bus control block.
// Assumes the memory model answers ready with a set wait count.
`timescale 1ns/1ps

module tb_cbc_bus_ctrl;
  import cbc_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic             clk, nrst, req_valid, req_ready, instr_last;
  logic             irq_enable_flag, wait_exec, ready, hold_req;
  logic             maskable_irq, nonmaskable_irq, wait_release_input;
  logic             sys_reset, config_mode_strap, upper_half_enable_n;
  logic             upper_half_enable_oe, low_byte_select_n;
  logic             low_byte_select_oe, read_strobe_n, read_strobe_oe;
  logic             ad_drive_oe, hold_ack, cycle_done, irq_take, irq_nmi;
  logic             wait_idle, exec_restart, mode_max;
  logic [7:0]       inta_type;
  logic [3:0]       waits;
  logic [VEC_W-1:0] vector_addr;
  cbc_req_t         req;
  int               fail_count, compares;

  cbc_bus_ctrl dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .instr_last(instr_last),
    .irq_enable_flag(irq_enable_flag), .inta_type(inta_type),
    .wait_exec(wait_exec), .ready(ready), .hold_req(hold_req),
    .maskable_irq(maskable_irq), .nonmaskable_irq(nonmaskable_irq),
    .wait_release_input(wait_release_input), .sys_reset(sys_reset),
    .config_mode_strap(config_mode_strap),
    .upper_half_enable_n(upper_half_enable_n),
    .upper_half_enable_oe(upper_half_enable_oe),
    .low_byte_select_n(low_byte_select_n),
    .low_byte_select_oe(low_byte_select_oe),
    .read_strobe_n(read_strobe_n), .read_strobe_oe(read_strobe_oe),
    .ad_drive_oe(ad_drive_oe), .hold_ack(hold_ack),
    .cycle_done(cycle_done), .irq_take(irq_take), .irq_nmi(irq_nmi),
    .vector_addr(vector_addr), .wait_idle(wait_idle),
    .exec_restart(exec_restart), .mode_max(mode_max));

  cbc_mem_model mem (.clk(clk), .nrst(nrst), .t1_mark(ad_drive_oe),
    .waits(waits), .ready(ready));

  always #(clk ? 3.3 : 6.7) clk = ~clk;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = ad_drive_oe;
      1: pick = cycle_done;
      2: pick = irq_take;
      3: pick = hold_ack;
      4: pick = wait_idle;
      5: pick = !wait_idle;
      default: pick = exec_restart;
    endcase
  endfunction

  task automatic wait_on(input int s, output int n);
    n = 0;
    while (pick(s) !== 1'b1) begin
      step();
      n++;
      if (n > 200) begin
        fail_count++;
        $display("[ERR] %0t wait timed out", $time);
        complete_run();
      end
    end
  endtask

  task automatic push(input cbc_req_t r, input int lim, output bit ok);
    ok = 0;
    req = r;
    for (int i = 0; i < lim && !ok; i++) begin
      if (req_ready === 1'b1) begin
        req_valid = 1'b1;
        ok = 1;
      end
      step();
    end
    req_valid = 1'b0;
  endtask

  task automatic bus(input cbc_req_t r, input int w, input logic [1:0] ln);
    int n;
    int k;
    bit ok;
    waits = w[3:0];
    push(r, 4, ok);
    wait_on(0, n);
    chk({upper_half_enable_n, low_byte_select_n}, ln);
    chk(low_byte_select_oe, 1'b1);
    chk(read_strobe_n, 1'b1);
    step();
    chk(upper_half_enable_n, STATUS_S7);
    n = 0;
    for (k = 0; k < 50 && cycle_done !== 1'b1; k++) begin
      n += (read_strobe_n === 1'b0);
      step();
    end
    wait_on(1, k);
    chk(12'(n), 12'((r.kind == KIND_READ) ? 2 + w : 0));
    chk(upper_half_enable_n, STATUS_S7);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic reset_test();
    chk({upper_half_enable_n, low_byte_select_n, read_strobe_n}, 3'h7);
    chk({upper_half_enable_oe, read_strobe_oe, ad_drive_oe}, 3'h0);
  endtask

  task automatic lanes_test();
    bus(cbc_req_t'({KIND_READ, 3'b001}), 0, LANE_WORD);
    bus(cbc_req_t'({KIND_READ, 3'b010}), 2, LANE_ODD);
    bus(cbc_req_t'({KIND_READ, 3'b000}), 1, LANE_EVEN);
    bus(cbc_req_t'({KIND_WRITE, 3'b011}), 0, LANE_WORD);
    bus(cbc_req_t'({KIND_INTA, 3'b100}), 0, 2'h0);
  endtask

  task automatic irq_test();
    int n;
    inta_type = 8'h21;
    maskable_irq = 1'b1;
    instr_last = 1'b1;
    n = 0;
    repeat (10) begin
      step();
      n += (irq_take === 1'b1);
    end
    chk(n, 0);
    nonmaskable_irq = 1'b1;
    wait_on(2, n);
    chk({irq_nmi, vector_addr}, {1'b1, NMI_TYPE, 2'h0});
    nonmaskable_irq = 1'b0;
    irq_enable_flag = 1'b1;
    step();
    wait_on(2, n);
    chk({irq_nmi, vector_addr}, {1'b0, 8'h21, 2'h0});
    maskable_irq = 1'b0;
    instr_last = 1'b0;
  endtask

  task automatic wait_test();
    int n;
    wait_exec = 1'b1;
    wait_release_input = 1'b1;
    wait_on(4, n);
    chk(n, 3);
    wait_release_input = 1'b0;
    wait_on(5, n);
    chk(n, 3);
    wait_exec = 1'b0;
  endtask

  task automatic hold_fill();
    int acc, n;
    bit ok;
    hold_req = 1'b1;
    wait_on(3, n);
    step();
    chk({upper_half_enable_oe, read_strobe_oe}, 2'h0);
    acc = 0;
    ok = 1;
    while (ok && acc < 20) begin
      push(cbc_req_t'({KIND_READ, 3'b001}), 4, ok);
      acc += ok;
    end
    chk(12'(acc), 12'(FIFO_DEPTH));
    hold_req = 1'b0;
    waits = 4'h1;
    n = 0;
    for (int i = 0; i < 400; i++) begin
      n += (cycle_done === 1'b1);
      step();
    end
    chk(12'(n), 12'(acc));
  endtask

  task automatic sysrst_test();
    int n;
    config_mode_strap = 1'b0;
    sys_reset = 1'b1;
    repeat (4) step();
    chk(req_ready, 1'b0);
    sys_reset = 1'b0;
    wait_on(6, n);
    chk(n, 3);
    chk(mode_max, 1'b1);
  endtask

  initial begin
    {clk, nrst, req_valid, instr_last, irq_enable_flag, wait_exec} = 6'h00;
    {hold_req, maskable_irq, nonmaskable_irq, sys_reset} = 4'h0;
    {wait_release_input, config_mode_strap} = 2'h1;
    req = '0;
    inta_type = 8'h00;
    waits = 4'h0;
    repeat (3) @(posedge clk);
    #1;
    reset_test();
    nrst = 1'b1;
    step();
    chk({upper_half_enable_oe, read_strobe_oe, req_ready}, 3'h7);
    lanes_test();
    irq_test();
    wait_test();
    hold_fill();
    sysrst_test();
    complete_run();
  end
endmodule
